// >>> bench/dag_top_sva.sv
// Port-level checker for the data address generator
`timescale 1ns/1ns
module dag_top_sva
    import dag_pkg::*;
#(
    parameter logic [15:0] IMPL_BANKS = DAG_IMPL_BANKS_RST
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input dag_class_t op_class,
    input wire logic [7:0] op_file_addr,
    input wire logic op_access,
    input wire logic op_dest,
    input wire logic [11:0] op_abs_addr,
    input wire logic [7:0] op_literal,
    input wire logic [19:0] op_prog_addr,
    input wire logic op_reads_file,
    input wire logic op_writes_file,
    input wire logic [7:0] wr_data,
    input wire logic [11:0] mem_addr_q,
    input wire logic mem_rd_en_q,
    input wire logic mem_wr_en_q,
    input wire logic res_to_w_q,
    input wire logic lit_valid_q,
    input wire logic [7:0] literal_q,
    input wire logic jump_valid_q,
    input wire logic [19:0] prog_addr_q,
    input wire logic op_done_q,
    input wire logic [3:0] bank_select_reg_q,
    input wire logic [11:0] pointer_pair_0_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Direct op in flight; low nibble of write data for the bank load
    logic dir;
    logic [3:0] wr_lo;
    logic bank_ok;
    assign dir = op_valid && op_class == DAG_CL_DIRECT;
    assign wr_lo = wr_data[3:0];
    assign bank_ok = IMPL_BANKS[bank_select_reg_q];

    // Read through pair 0 with a pointer below the special area
    sequence s_vop0(f);
        dir && !op_access && op_file_addr == f && !op_writes_file
            && pointer_pair_0_q < 12'hfd9;
    endsequence

    a_op_done: assert property (op_valid |=> op_done_q)
        else $error("op done pulse missing");
    a_window_low: assert property (dir && !op_access && op_reads_file
        && op_file_addr < 8'h60 |=> mem_rd_en_q
        && mem_addr_q == {4'h0, $past(op_file_addr)})
        else $error("window address wrong");
    a_banked_addr: assert property (dir && op_access && op_reads_file
        && bank_ok && bank_select_reg_q != 4'hf |=> mem_rd_en_q
        && mem_addr_q == {$past(bank_select_reg_q), $past(op_file_addr)})
        else $error("banked address wrong");
    a_unimpl_bank: assert property (dir && op_access && !bank_ok
        |=> !mem_rd_en_q && !mem_wr_en_q)
        else $error("absent bank accessed");
    a_abs_direct: assert property (op_valid
        && op_class == DAG_CL_ABSOLUTE && op_reads_file
        && op_abs_addr < 12'hf00 |=> mem_addr_q == $past(op_abs_addr))
        else $error("absolute address wrong");
    a_dest_sel: assert property (dir |=> res_to_w_q == !$past(op_dest))
        else $error("destination select wrong");
    a_lit_pass: assert property (op_valid && op_class == DAG_CL_LITERAL
        |=> lit_valid_q && literal_q == $past(op_literal))
        else $error("literal not passed");
    a_jump_pass: assert property (op_valid && op_class == DAG_CL_BRANCH
        |=> jump_valid_q && prog_addr_q == $past(op_prog_addr))
        else $error("jump address not passed");
    a_bank_load: assert property (dir && !op_access
        && op_file_addr == 8'he0 && op_writes_file && op_dest
        |=> bank_select_reg_q == $past(wr_lo))
        else $error("bank load wrong");
    a_post_increment_operand_step: assert property (s_vop0(8'hee)
        |=> pointer_pair_0_q == $past(pointer_pair_0_q) + 12'h001)
        else $error("post increment step wrong");
    a_post_decrement_operand_step: assert property (s_vop0(8'hed)
        |=> pointer_pair_0_q == $past(pointer_pair_0_q) - 12'h001)
        else $error("post decrement step wrong");
    a_pre_increment_operand_addr: assert property (s_vop0(8'hec)
        |=> mem_addr_q == $past(pointer_pair_0_q) + 12'h001)
        else $error("pre increment address wrong");
endmodule

bind dag_top dag_top_sva #(.IMPL_BANKS(IMPL_BANKS)) i_sva (.*);

// >>> bench/data_address_generator_tb.sv
// Self-checking bench for the data address generator
`timescale 1ns/1ns
`define CK(n, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("wrong value %s exp %h got %h", n, e, g); \
        end \
    end
module data_address_generator_tb
    import dag_pkg::*;
;
    logic mclk = 0, rst = 1, op_valid = 0, op_access = 0, op_dest = 0;
    logic op_reads_file = 0, op_writes_file = 0;
    dag_class_t op_class = DAG_CL_INHERENT;
    logic [7:0] op_file_addr = 8'h00, op_literal = 8'h3c;
    logic [7:0] wr_data = 8'h00, w_reg = 8'h00;
    logic [11:0] op_abs_addr = 12'habc, mem_addr_q;
    logic [11:0] pointer_pair_0_q, pointer_pair_1_q, pointer_pair_2_q;
    logic [19:0] op_prog_addr = 20'h12345, prog_addr_q;
    logic mem_rd_en_q, mem_wr_en_q, rd_zero_q, rd_local_q, res_to_w_q;
    logic lit_valid_q, jump_valid_q, op_done_q;
    logic [7:0] mem_wr_data_q, rd_local_data_q, literal_q;
    logic [3:0] bank_select_reg_q;
    int miscompares = 0, checks = 0, cycles = 0;

    // Bank 2 left out so the absent-bank path is reachable
    dag_top #(.IMPL_BANKS(16'hfffb)) i_dut (.*);

    always #10 mclk = ~mclk;

    // Cut a hang short; the sequence needs well under 100 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 600)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One instruction, taken at the next edge; outputs settled after it
    task automatic op(input dag_class_t c, input logic [7:0] f,
                      input logic a, input logic d, input logic r,
                      input logic w, input logic [7:0] dat);
        op_valid = 1;
        op_class = c;
        op_file_addr = f;
        op_access = a;
        op_dest = d;
        op_reads_file = r;
        op_writes_file = w;
        wr_data = dat;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] f, input logic a);
        op(DAG_CL_DIRECT, f, a, 1, 1, 0, 8'h00);
    endtask

    task automatic wrf(input logic [7:0] f, input logic [7:0] dat);
        op(DAG_CL_DIRECT, f, 0, 1, 0, 1, dat);
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        #1 rst = 0;
        `CK("bank", 4'h0, bank_select_reg_q)
        `CK("ptr0", 12'h000, pointer_pair_0_q)
        $display("test reset done");
        wrf(8'he0, 8'hf7);
        `CK("bank", 4'h7, bank_select_reg_q)
        rd(8'he0, 0);
        `CK("bank read", 8'h07, rd_local_data_q)
        `CK("local", 1'b1, rd_local_q)
        wrf(8'he0, 8'h02);
        rd(8'h34, 1);
        `CK("zero", 1'b1, rd_zero_q)
        `CK("rd en", 1'b0, mem_rd_en_q)
        op(DAG_CL_DIRECT, 8'h34, 1, 1, 0, 1, 8'h99);
        `CK("wr en", 1'b0, mem_wr_en_q)
        wrf(8'he0, 8'h05);
        rd(8'h34, 1);
        `CK("addr", 12'h534, mem_addr_q)
        rd(8'h34, 0);
        `CK("addr", 12'h034, mem_addr_q)
        rd(8'h80, 0);
        `CK("addr", 12'hf80, mem_addr_q)
        $display("test direct done");
        op(DAG_CL_DIRECT, 8'h34, 0, 0, 1, 1, 8'h00);
        `CK("to w", 1'b1, res_to_w_q)
        `CK("wr en", 1'b0, mem_wr_en_q)
        op(DAG_CL_DIRECT, 8'h34, 0, 1, 1, 1, 8'ha5);
        `CK("to w", 1'b0, res_to_w_q)
        `CK("wr en", 1'b1, mem_wr_en_q)
        `CK("wr data", 8'ha5, mem_wr_data_q)
        op(DAG_CL_ABSOLUTE, 8'h00, 0, 1, 1, 0, 8'h00);
        `CK("addr", 12'habc, mem_addr_q)
        op(DAG_CL_ABSOLUTE, 8'h00, 0, 0, 0, 1, 8'h77);
        `CK("wr en", 1'b1, mem_wr_en_q)
        `CK("addr", 12'habc, mem_addr_q)
        op(DAG_CL_LITERAL, 8'h00, 0, 0, 0, 0, 8'h00);
        `CK("literal", 8'h3c, literal_q)
        `CK("lit valid", 1'b1, lit_valid_q)
        op(DAG_CL_BRANCH, 8'h00, 0, 0, 0, 0, 8'h00);
        `CK("jump", 20'h12345, prog_addr_q)
        `CK("jump valid", 1'b1, jump_valid_q)
        op(DAG_CL_INHERENT, 8'h00, 0, 0, 0, 0, 8'h00);
        `CK("rd en", 1'b0, mem_rd_en_q)
        $display("test classes done");
        wrf(8'he9, 8'hff);
        wrf(8'hea, 8'hf0);
        `CK("ptr0", 12'h0ff, pointer_pair_0_q)
        rd(8'hea, 0);
        `CK("high read", 8'h00, rd_local_data_q)
        rd(8'hee, 0);
        `CK("addr", 12'h0ff, mem_addr_q)
        `CK("ptr0", 12'h100, pointer_pair_0_q)
        rd(8'hed, 0);
        `CK("addr", 12'h100, mem_addr_q)
        `CK("ptr0", 12'h0ff, pointer_pair_0_q)
        rd(8'hec, 0);
        `CK("addr", 12'h100, mem_addr_q)
        rd(8'hef, 0);
        `CK("ptr0", 12'h100, pointer_pair_0_q)
        w_reg = 8'hff;
        rd(8'heb, 0);
        `CK("addr", 12'h0ff, mem_addr_q)
        w_reg = 8'h7f;
        rd(8'heb, 0);
        `CK("addr", 12'h17f, mem_addr_q)
        `CK("ptr0", 12'h100, pointer_pair_0_q)
        op(DAG_CL_DIRECT, 8'hef, 0, 1, 1, 1, 8'h66);
        `CK("addr", 12'h100, mem_addr_q)
        `CK("wr data", 8'h66, mem_wr_data_q)
        rd(8'hee, 0);
        rd(8'hee, 0);
        `CK("addr", 12'h101, mem_addr_q)
        `CK("ptr0", 12'h102, pointer_pair_0_q)
        $display("test pointers done");
        wrf(8'he1, 8'hef);
        wrf(8'he2, 8'h0f);
        `CK("ptr1", 12'hfef, pointer_pair_1_q)
        rd(8'he7, 0);
        `CK("zero", 1'b1, rd_zero_q)
        `CK("rd en", 1'b0, mem_rd_en_q)
        op(DAG_CL_DIRECT, 8'he7, 0, 1, 1, 1, 8'h11);
        `CK("wr en", 1'b0, mem_wr_en_q)
        `CK("ptr0", 12'h102, pointer_pair_0_q)
        wrf(8'hd9, 8'hd9);
        wrf(8'hda, 8'h0f);
        op(DAG_CL_DIRECT, 8'hdd, 0, 1, 1, 1, 8'h44);
        `CK("ptr2", 12'hf44, pointer_pair_2_q)
        $display("test special cases done");
        op_valid = 0;
        @(posedge mclk);
        #1;
        `CK("done", 1'b0, op_done_q)
        summarize();
    end
endmodule

// >>> inc/dag_pkg.sv
// Constants and types shared by the data address generator
package dag_pkg;

    // Widths of the data path
    localparam int DAG_ADDR_W = 12;
    localparam int DAG_DATA_W = 8;
    localparam int DAG_PADDR_W = 20;
    localparam int DAG_NPAIR = 3;

    // Access window split and fixed banks
    localparam logic [7:0] DAG_ACC_SPLIT = 8'h60;
    localparam logic [3:0] DAG_LOW_BANK = 4'h0;
    localparam logic [3:0] DAG_SFR_BANK = 4'hf;

    // Special-function addresses kept in this block
    localparam logic [11:0] DAG_BSR_ADDR = 12'hfe0;
    // Low byte of each pointer pair; the high byte sits one above
    localparam logic [11:0] DAG_PTR_LO_ADDR [DAG_NPAIR] =
        '{12'hfe9, 12'he1 + 12'hf00, 12'hfd9};
    // First virtual operand of each pair, in the order w-offset,
    // pre-increment, post-decrement, post-increment, plain
    localparam logic [11:0] DAG_VIRT_BASE [DAG_NPAIR] =
        '{12'hfeb, 12'hfe3, 12'hfdb};
    localparam logic [11:0] DAG_VIRT_SPAN = 12'h005;

    // Values after reset
    localparam logic [11:0] DAG_PTR_RST = 12'h000;
    localparam logic [3:0] DAG_BSR_RST = 4'h0;
    localparam logic [15:0] DAG_IMPL_BANKS_RST = 16'hffff;

    // Addressing class of the instruction in flight
    typedef enum logic [4:0] {
        DAG_CL_INHERENT = 5'b00001,
        DAG_CL_LITERAL = 5'b00010,
        DAG_CL_DIRECT = 5'b00100,
        DAG_CL_ABSOLUTE = 5'b01000,
        DAG_CL_BRANCH = 5'b10000
    } dag_class_t;

    // Virtual operand kinds
    typedef enum logic [5:0] {
        DAG_VOP_NONE = 6'b000001,
        DAG_VOP_PLAIN = 6'b000010,
        DAG_VOP_POST_INCREMENT_OPERAND = 6'b000100,
        DAG_VOP_POST_DECREMENT_OPERAND = 6'b001000,
        DAG_VOP_PRE_INCREMENT_OPERAND = 6'b010000,
        DAG_VOP_W_OFFSET_OPERAND = 6'b100000
    } dag_vop_t;

    typedef struct packed {
        logic hit;
        logic [1:0] pair;
        dag_vop_t op;
    } dag_virt_t;

    typedef struct packed {
        logic hit;
        logic [1:0] pair;
        logic hi;
    } dag_ptrhit_t;

endpackage

// >>> inc/dag_ptr_if.sv
// Control and value lines between the generator and one pointer pair
`timescale 1ns/1ns
interface dag_ptr_if #(parameter int PTR_W = 12);
    logic load_lo;
    logic load_hi;
    logic [7:0] load_data;
    logic inc;
    logic dec;
    logic [PTR_W-1:0] value;

    modport pair (input load_lo, input load_hi, input load_data,
                  input inc, input dec, output value);
    modport ctl (output load_lo, output load_hi, output load_data,
                 output inc, output dec, input value);
endinterface

// >>> verilog/dag_ptr_pair.sv
// One pointer pair: high and low byte held as one linear value
`timescale 1ns/1ns
module dag_ptr_pair
    import dag_pkg::*;
#(
    parameter int PTR_W = DAG_ADDR_W
)
(
    input wire logic mclk,
    input wire logic rst,
    dag_ptr_if.pair port
);

    logic [PTR_W-1:0] value_q;

    // A byte load wins over any step, so a write landing on the pair
    // stores exactly the written value
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            value_q <= PTR_W'(DAG_PTR_RST);
        end
        else if (port.load_lo || port.load_hi)
        begin
            if (port.load_lo)
            begin
                value_q[7:0] <= port.load_data;
            end
            if (port.load_hi)
            begin
                value_q[PTR_W-1:8] <= port.load_data[PTR_W-9:0];
            end
        end
        else if (port.inc)
        begin
            value_q <= value_q + PTR_W'(1); // Carries across bytes
        end
        else if (port.dec)
        begin
            value_q <= value_q - PTR_W'(1); // Borrows across bytes
        end
    end

    assign port.value = value_q;

endmodule

// >>> verilog/dag_top.sv
// Operand address generator for the data memory of an 8-bit core
// Operation
// - Low address byte comes from the opcode's low 8-bit field.
// - Access bit one: bank select joined above the 8-bit field.
// - Access bit zero: bank select ignored, address in access window.
// - Full 12-bit opcode addresses are used directly, bank ignored.
// - Destination bit one writes back to file, zero to working register; absolute ops write the file either way.
// - Inherent has no operand; literal carries value; jumps 20-bit.
// - Three pointer pairs of two bytes hold 12-bit addresses.
// - Plain indirect accesses pointer location, pointer unchanged.
// - Indirect access reaches any bank regardless of bank select.
// - Post-decrement accesses at pointer, then pointer minus one.
// - Post-increment accesses at pointer, then pointer plus one.
// - Pre-increment adds one first, then accesses new location.
// - W-offset accesses pointer plus signed W, nothing changes.
// - Steps act on the whole pair with carry or borrow.
// - Pointer steps never touch arithmetic status flags.
// - Indirect read landing on a virtual operand returns 00h.
// - Indirect write landing on a virtual operand stores nothing; the write is dropped, yet pre/post steps still apply.
// - Write through a pair onto itself stores value, no step.
// - Pointer bytes are real registers reachable by any access.
// - Bank select keeps four bits; upper bits read zero.
// - Window 00h-5Fh is bank zero bottom, 60h-FFh bank fifteen top.
// - Unimplemented banks ignore writes and read as zeros.
`timescale 1ns/1ns
module dag_top
    import dag_pkg::*;
#(
    parameter logic [15:0] IMPL_BANKS = DAG_IMPL_BANKS_RST
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input dag_class_t op_class,
    input wire logic [7:0] op_file_addr,
    input wire logic op_access,
    input wire logic op_dest,
    input wire logic [DAG_ADDR_W-1:0] op_abs_addr,
    input wire logic [DAG_DATA_W-1:0] op_literal,
    input wire logic [DAG_PADDR_W-1:0] op_prog_addr,
    input wire logic op_reads_file,
    input wire logic op_writes_file,
    input wire logic [DAG_DATA_W-1:0] wr_data,
    input wire logic [DAG_DATA_W-1:0] w_reg,
    output logic [DAG_ADDR_W-1:0] mem_addr_q,
    output logic mem_rd_en_q,
    output logic mem_wr_en_q,
    output logic [DAG_DATA_W-1:0] mem_wr_data_q,
    output logic rd_zero_q,
    output logic rd_local_q,
    output logic [DAG_DATA_W-1:0] rd_local_data_q,
    output logic res_to_w_q,
    output logic lit_valid_q,
    output logic [DAG_DATA_W-1:0] literal_q,
    output logic jump_valid_q,
    output logic [DAG_PADDR_W-1:0] prog_addr_q,
    output logic op_done_q,
    output logic [3:0] bank_select_reg_q,
    output logic [DAG_ADDR_W-1:0] pointer_pair_0_q,
    output logic [DAG_ADDR_W-1:0] pointer_pair_1_q,
    output logic [DAG_ADDR_W-1:0] pointer_pair_2_q
);

    dag_ptr_if #(.PTR_W(DAG_ADDR_W)) pif [DAG_NPAIR] ();

    logic [DAG_ADDR_W-1:0] ptr_val [DAG_NPAIR];
    logic ld_lo [DAG_NPAIR];
    logic ld_hi [DAG_NPAIR];
    logic step_inc [DAG_NPAIR];
    logic step_dec [DAG_NPAIR];

    logic [DAG_ADDR_W-1:0] dir_addr;
    logic [DAG_ADDR_W-1:0] eff_addr;
    logic [DAG_ADDR_W-1:0] src_ptr;
    dag_virt_t src_virt;
    dag_virt_t dst_virt;
    dag_ptrhit_t dst_ptr;
    logic has_file;
    logic do_read;
    logic do_write;
    logic blocked;
    logic bank_ok;
    logic is_local;
    logic bsr_hit;
    logic [DAG_DATA_W-1:0] local_data;

    // Map an address onto the virtual operand it names, if any
    function automatic dag_virt_t virt_of(input logic [11:0] a);
        dag_virt_t r;
        logic [11:0] off;
        r = '{hit: 1'b0, pair: 2'd0, op: DAG_VOP_NONE};
        off = 12'h000;
        for (int p = 0; p < DAG_NPAIR; p++)
        begin
            if (a >= DAG_VIRT_BASE[p] &&
                a < DAG_VIRT_BASE[p] + DAG_VIRT_SPAN)
            begin
                off = a - DAG_VIRT_BASE[p];
                r.hit = 1'b1;
                r.pair = 2'(p);
                case (off[2:0])
                    3'h0: r.op = DAG_VOP_W_OFFSET_OPERAND;
                    3'h1: r.op = DAG_VOP_PRE_INCREMENT_OPERAND;
                    3'h2: r.op = DAG_VOP_POST_DECREMENT_OPERAND;
                    3'h3: r.op = DAG_VOP_POST_INCREMENT_OPERAND;
                    default: r.op = DAG_VOP_PLAIN;
                endcase
            end
        end
        return r;
    endfunction

    // Map an address onto a pointer byte, if any
    function automatic dag_ptrhit_t ptr_of(input logic [11:0] a);
        dag_ptrhit_t r;
        r = '{hit: 1'b0, pair: 2'd0, hi: 1'b0};
        for (int p = 0; p < DAG_NPAIR; p++)
        begin
            if (a == DAG_PTR_LO_ADDR[p] ||
                a == DAG_PTR_LO_ADDR[p] + 12'h001)
            begin
                r.hit = 1'b1;
                r.pair = 2'(p);
                r.hi = (a != DAG_PTR_LO_ADDR[p]);
            end
        end
        return r;
    endfunction

    // Pointer pairs, one instance each
    for (genvar g = 0; g < DAG_NPAIR; g++)
    begin : g_pair
        dag_ptr_pair #(.PTR_W(DAG_ADDR_W)) u_pair (
            .mclk(mclk),
            .rst(rst),
            .port(pif[g])
        );
        assign pif[g].load_lo = ld_lo[g];
        assign pif[g].load_hi = ld_hi[g];
        assign pif[g].load_data = wr_data;
        assign pif[g].inc = step_inc[g];
        assign pif[g].dec = step_dec[g];
        assign ptr_val[g] = pif[g].value;
    end

    assign pointer_pair_0_q = ptr_val[0];
    assign pointer_pair_1_q = ptr_val[1];
    assign pointer_pair_2_q = ptr_val[2];

    // Direct address: banked, access window or full opcode address
    always_comb
    begin
        dir_addr = {DAG_LOW_BANK, op_file_addr};
        if (op_class == DAG_CL_ABSOLUTE)
        begin
            dir_addr = op_abs_addr;
        end
        else if (op_access)
        begin
            dir_addr = {bank_select_reg_q, op_file_addr};
        end
        else if (op_file_addr >= DAG_ACC_SPLIT)
        begin
            dir_addr = {DAG_SFR_BANK, op_file_addr};
        end
    end

    // Resolve indirect operands to the pointed-at location
    always_comb
    begin
        has_file = op_valid &&
            (op_class == DAG_CL_DIRECT || op_class == DAG_CL_ABSOLUTE);
        src_virt = virt_of(dir_addr);
        if (!has_file)
        begin
            src_virt.hit = 1'b0;
        end
        src_ptr = ptr_val[src_virt.pair];
        eff_addr = dir_addr;
        if (src_virt.hit)
        begin
            // Full pointer value, bank select plays no part
            case (src_virt.op)
                DAG_VOP_PRE_INCREMENT_OPERAND: eff_addr = src_ptr + 12'h001;
                DAG_VOP_W_OFFSET_OPERAND:
                    eff_addr = src_ptr + {{4{w_reg[7]}}, w_reg};
                default: eff_addr = src_ptr;
            endcase
        end
        dst_virt = virt_of(eff_addr);
        dst_ptr = ptr_of(eff_addr);
    end

    // Access qualification
    always_comb
    begin
        // Result goes to the file with destination bit set, or always for absolute ops
        do_write = has_file && op_writes_file &&
            (op_class == DAG_CL_ABSOLUTE || op_dest);
        do_read = has_file && op_reads_file;
        // Pointer chasing onto a virtual operand is refused
        blocked = src_virt.hit && dst_virt.hit;
        bank_ok = IMPL_BANKS[eff_addr[11:8]];
        bsr_hit = (eff_addr == DAG_BSR_ADDR);
        is_local = dst_ptr.hit || bsr_hit;
    end

    // Byte shown for reads of registers held in this block
    always_comb
    begin
        local_data = {4'h0, bank_select_reg_q};
        if (dst_ptr.hit)
        begin
            if (dst_ptr.hi)
            begin
                local_data = {4'h0, ptr_val[dst_ptr.pair][11:8]};
            end
            else
            begin
                local_data = ptr_val[dst_ptr.pair][7:0];
            end
        end
    end

    // Pointer loads and steps; no status flag path exists here
    always_comb
    begin
        for (int p = 0; p < DAG_NPAIR; p++)
        begin
            ld_lo[p] = do_write && !blocked && dst_ptr.hit &&
                dst_ptr.pair == 2'(p) && !dst_ptr.hi;
            ld_hi[p] = do_write && !blocked && dst_ptr.hit &&
                dst_ptr.pair == 2'(p) && dst_ptr.hi;
            step_inc[p] = src_virt.hit && src_virt.pair == 2'(p) &&
                (src_virt.op == DAG_VOP_POST_INCREMENT_OPERAND ||
                 src_virt.op == DAG_VOP_PRE_INCREMENT_OPERAND);
            step_dec[p] = src_virt.hit && src_virt.pair == 2'(p) &&
                src_virt.op == DAG_VOP_POST_DECREMENT_OPERAND;
        end
    end

    // Bank select: four bits kept, written by any write that lands on it
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bank_select_reg_q <= DAG_BSR_RST;
        end
        else if (do_write && !blocked && bsr_hit)
        begin
            bank_select_reg_q <= wr_data[3:0];
        end
    end

    // Memory request for the resolved address, one cycle after the op
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mem_addr_q <= '0;
            mem_rd_en_q <= 1'b0;
            mem_wr_en_q <= 1'b0;
            mem_wr_data_q <= '0;
        end
        else
        begin
            mem_addr_q <= eff_addr;
            mem_rd_en_q <= do_read && !blocked && bank_ok && !is_local;
            // Locally held registers and refused targets stay off the bus
            mem_wr_en_q <= do_write && !blocked && bank_ok &&
                !is_local;
            mem_wr_data_q <= wr_data;
        end
    end

    // Read answer for the operand: zero, local byte or memory
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_zero_q <= 1'b0;
            rd_local_q <= 1'b0;
            rd_local_data_q <= '0;
        end
        else
        begin
            rd_zero_q <= do_read && (blocked || !bank_ok);
            rd_local_q <= do_read && !blocked && is_local;
            rd_local_data_q <= local_data;
        end
    end

    // Result steering: a direct op with the destination bit clear
    // hands its result to the working register instead of the file
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            res_to_w_q <= 1'b0;
        end
        else
        begin
            res_to_w_q <= has_file && op_class == DAG_CL_DIRECT &&
                !op_dest;
        end
    end

    // Literal operand, passed through with its valid pulse
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            lit_valid_q <= 1'b0;
            literal_q <= '0;
        end
        else
        begin
            lit_valid_q <= op_valid && op_class == DAG_CL_LITERAL;
            literal_q <= op_literal;
        end
    end

    // Program address of a call or jump; the data path never uses it
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            jump_valid_q <= 1'b0;
            prog_addr_q <= '0;
        end
        else
        begin
            jump_valid_q <= op_valid && op_class == DAG_CL_BRANCH;
            prog_addr_q <= op_prog_addr;
        end
    end

    // Completion pulse, one per accepted op; inherent ops only raise
    // this. Pointer updates land on this same edge, so the next op
    // already sees them and no stall cycle is needed
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            op_done_q <= 1'b0;
        end
        else
        begin
            op_done_q <= op_valid;
        end
    end

endmodule
